/* File: rtl/scan_link.v */
// Module-side logic of the rear serial link and channel scan counter.
// Assumes all link pins come from the host asynchronously to clk.
//
// Behaviour
// - Qualifier low means data word, high address.
// - Accept serial traffic only while slot line high.
// - Shift serial input into registers on shift clock.
// - Shift clock times both directions of transfer.
// - Drive serial data out for host reads.
// - Scan clock rising edge advances channel counter.
// - Multiplexed mode: counter selects routed channel.
// - Parallel mode: selected channel, zero after reset.
`include "scan_link_map.vh"
module scan_link #(
  parameter WORD_BITS = `WORD_BITS
) (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Serial link pins from the host.
  input wire host_serial_in,
  input wire shift_clock,
  input wire word_kind_qualifier,
  input wire backplane_slot_line_n,
  input wire scan_clock,
  // Serial link pin toward the host.
  output reg module_serial_out,
  // Analog multiplexer control.
  output reg [`CHAN_BITS-1:0] main_out_select,
  output reg mux_mode
);
  // Position of each link pin in the synchroniser bank.
  localparam PIN_SCK = 0;
  localparam PIN_SDI = 1;
  localparam PIN_KIND = 2;
  localparam PIN_SLOT = 3;
  localparam PIN_SCAN = 4;
  localparam PIN_COUNT = 5;
  // The bit counter must hold the index of the last bit of a word.
  localparam COUNT_BITS = 4;
  localparam integer COUNT_LAST = WORD_BITS - 1;
  localparam [COUNT_BITS-1:0] COUNT_ZERO = {COUNT_BITS{1'h0}};
  localparam [COUNT_BITS-1:0] COUNT_ONE = {{(COUNT_BITS-1){1'h0}}, 1'h1};

  wire [PIN_COUNT-1:0] pin_raw;
  wire [PIN_COUNT-1:0] pin_level;
  wire [PIN_COUNT-1:0] pin_rise;
  wire [PIN_COUNT-1:0] pin_fall;
  wire sck_rise;
  wire sck_fall;
  wire sdi_level;
  wire kind_level;
  wire slot_level;
  wire scan_rise;

  assign pin_raw[PIN_SCK] = shift_clock;
  assign pin_raw[PIN_SDI] = host_serial_in;
  assign pin_raw[PIN_KIND] = word_kind_qualifier;
  assign pin_raw[PIN_SLOT] = backplane_slot_line_n;
  assign pin_raw[PIN_SCAN] = scan_clock;

  // All link pins share one synchroniser depth, so data and qualifier
  // levels keep their place relative to the shift clock edges.
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_sync
      pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin(pin_raw[g]),
        .level_q(pin_level[g]),
        .rise(pin_rise[g]),
        .fall(pin_fall[g])
      );
    end
  endgenerate

  assign sck_rise = pin_rise[PIN_SCK];
  assign sck_fall = pin_fall[PIN_SCK];
  assign sdi_level = pin_level[PIN_SDI];
  assign kind_level = pin_level[PIN_KIND];
  assign slot_level = pin_level[PIN_SLOT];
  assign scan_rise = pin_rise[PIN_SCAN];

  // Mode decode of the control register.
  function mode_of(input [WORD_BITS-1:0] ctrl);
    mode_of = ctrl[`CTRL_MODE_BIT];
  endfunction

  // Step to the following channel, wrapping after the last one.
  function [`CHAN_BITS-1:0] next_chan(input [`CHAN_BITS-1:0] chan);
    if (chan == `CHAN_LAST) begin
      next_chan = `CHAN_RESET;
    end else begin
      next_chan = chan + 3'h1;
    end
  endfunction

  // Serial shifter state.
  reg [WORD_BITS-1:0] shift_q;
  reg [WORD_BITS-1:0] shift_d;
  reg [COUNT_BITS-1:0] count_q;
  reg [COUNT_BITS-1:0] count_d;
  reg [`REG_IDX_BITS-1:0] addr_q;
  reg [`REG_IDX_BITS-1:0] addr_d;
  reg [WORD_BITS-1:0] out_q;
  reg [WORD_BITS-1:0] out_d;
  reg serial_out_d;
  reg kind_prev_q;
  // Register file written by data words.
  reg [WORD_BITS-1:0] regs_q [0:`REG_COUNT-1];
  reg reg_write;
  // Channel scan state.
  reg [`CHAN_BITS-1:0] scan_q;
  reg [`CHAN_BITS-1:0] scan_d;
  reg [`CHAN_BITS-1:0] select_d;
  reg mode_d;
  wire selected;
  wire kind_changed;
  wire [WORD_BITS-1:0] shift_next;
  wire word_done;
  integer i;

  assign selected = (slot_level == `SLOT_MODULE);
  assign kind_changed = (kind_prev_q != kind_level);
  assign shift_next = {shift_q[WORD_BITS-2:0], sdi_level};
  assign word_done = sck_rise && (count_q == COUNT_LAST);

  // The bit counter restarts whenever the slot line or qualifier changes,
  // so a word cut short never bleeds into the next one. A qualifier change
  // also reloads the read-back word, so a shift clock edge that lands in
  // the same cycle is ignored on purpose.
  always @* begin
    shift_d = shift_q;
    count_d = count_q;
    addr_d = addr_q;
    out_d = out_q;
    serial_out_d = module_serial_out;
    reg_write = 1'h0;
    if (!selected || kind_changed) begin
      count_d = COUNT_ZERO;
      out_d = regs_q[addr_q];
    end else if (sck_rise) begin
      shift_d = shift_next;
      if (word_done) begin
        count_d = COUNT_ZERO;
        if (kind_level == `KIND_ADDR) begin
          addr_d = shift_next[`REG_IDX_BITS-1:0];
          out_d = regs_q[shift_next[`REG_IDX_BITS-1:0]];
        end else begin
          reg_write = 1'h1;
          out_d = shift_next;
        end
      end else begin
        count_d = count_q + COUNT_ONE;
      end
    end else if (sck_fall) begin
      serial_out_d = out_q[WORD_BITS-1];
      out_d = {out_q[WORD_BITS-2:0], 1'h0};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      shift_q <= `WORD_ZERO;
      count_q <= COUNT_ZERO;
      addr_q <= `ADDR_ZERO;
      kind_prev_q <= `KIND_DATA;
      out_q <= `WORD_ZERO;
      module_serial_out <= 1'h0;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
      addr_q <= addr_d;
      kind_prev_q <= kind_level;
      out_q <= out_d;
      module_serial_out <= serial_out_d;
    end
  end

  // The register file has its own process so that its reset loop stays
  // apart from the shifter state.
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < `REG_COUNT; i = i + 1) begin
        regs_q[i] <= `WORD_ZERO;
      end
    end else if (reg_write) begin
      regs_q[addr_q] <= shift_next;
    end
  end

  // The counter runs in both modes; only multiplexed mode routes it.
  // It is not cleared on a mode change, so software that needs a known
  // starting channel must reset the block first.
  always @* begin
    scan_d = scan_q;
    if (scan_rise) begin
      scan_d = next_chan(scan_q);
    end
    mode_d = mode_of(regs_q[`REG_CTRL]);
    if (mode_d == `MODE_MUX) begin
      select_d = scan_q;
    end else begin
      select_d = regs_q[`REG_CHAN][`CHAN_BITS-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      scan_q <= `CHAN_RESET;
      main_out_select <= `CHAN_RESET;
      mux_mode <= `MODE_PARALLEL;
    end else begin
      scan_q <= scan_d;
      main_out_select <= select_d;
      mux_mode <= mode_d;
    end
  end
endmodule // scan_link

/* File: rtl/scan_link_map.vh */
// Constants for the serial scan link block.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef SCAN_LINK_MAP_VH
`define SCAN_LINK_MAP_VH
`define WORD_BITS 8
`define CHAN_BITS 3
`define CHAN_COUNT 8
`define CHAN_RESET 3'h0
`define CHAN_LAST 3'h7
`define KIND_DATA 1'h0
`define KIND_ADDR 1'h1
`define SLOT_MODULE 1'h1
`define MODE_PARALLEL 1'h0
`define MODE_MUX 1'h1
`define REG_COUNT 4
`define REG_IDX_BITS 2
`define REG_CTRL 2'h0
`define REG_CHAN 2'h1
`define CTRL_MODE_BIT 0
`define WORD_ZERO 8'h00
`define ADDR_ZERO 2'h0
`endif

/* File: rtl/pin_sync.v */
// Three-stage synchroniser with edge detection for a pin input.
// Assumes the pin is asynchronous to clk; output moves once stages two and three agree.
`include "scan_link_map.vh"
module pin_sync (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Pin and decoded level and edges.
  input wire pin,
  output reg level_q,
  output wire rise,
  output wire fall
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
      s3_q <= 1'h0;
      level_q <= 1'h0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only when stages two and three agree.
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign rise = (s2_q == s3_q) && s3_q && !level_q;
  assign fall = (s2_q == s3_q) && !s3_q && level_q;
endmodule // pin_sync

/* File: verification/scan_link_properties.sv */
// Port checker for scan_link, bound after the module.
// Assumes link pins hold for several clk cycles.
module scan_link_properties (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Link pins from the host.
  input wire shift_clock,
  input wire word_kind_qualifier,
  input wire backplane_slot_line_n,
  input wire scan_clock,
  // Outputs of the block.
  input wire module_serial_out,
  input wire mux_mode,
  input wire [2:0] main_out_select
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reset_out_a: assert property (disable iff (1'b0)
    rst |=> {mux_mode, main_out_select, module_serial_out} == 5'h00)
    else $error("not cleared");
  mux_step_a: assert property (
    mux_mode && $past(mux_mode) && $changed(main_out_select)
    |-> main_out_select == $past(main_out_select) + 3'h1)
    else $error("bad step");
  scan_rise_a: assert property (mux_mode && $rose(scan_clock)
    |-> ##[2:7] $changed(main_out_select)) else $error("no step");
  mux_hold_a: assert property ($stable(scan_clock)[*7]
    ##0 (mux_mode && $past(mux_mode)) |-> $stable(main_out_select))
    else $error("mux moved");
  par_hold_a: assert property ($stable(shift_clock)[*7]
    ##0 (!mux_mode && !$past(mux_mode)) |-> $stable(main_out_select))
    else $error("par moved");
  slot_refuse_a: assert property (!backplane_slot_line_n[*8]
    |-> $stable(mux_mode)) else $error("slot write");
  addr_only_a: assert property (word_kind_qualifier[*8]
    |-> $stable(mux_mode)) else $error("addr write");
  out_hold_a: assert property (($stable(shift_clock) &&
    $stable(word_kind_qualifier) && $stable(backplane_slot_line_n))[*8]
    |-> $stable(module_serial_out)) else $error("out moved");
endmodule // scan_link_properties
bind scan_link scan_link_properties chk (.clk, .rst, .shift_clock,
  .word_kind_qualifier, .backplane_slot_line_n, .scan_clock,
  .module_serial_out, .mux_mode, .main_out_select);

/* File: verification/host_model.sv */
// Host board model driving the link pins and reading the return line.
// Assumes one task runs at a time and a block clock of 25 ns.
module host_model (
  // Pins toward the module.
  output logic host_serial_in,
  output logic shift_clock,
  output logic word_kind_qualifier,
  output logic backplane_slot_line_n,
  output logic scan_clock,
  // Return line from the module.
  input logic module_serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rd;
  initial {host_serial_in, shift_clock, word_kind_qualifier,
    backplane_slot_line_n, scan_clock} = 5'h00;
  initial rd = 8'h00;
  // The clock stands low between words. The return line is sampled just
  // before each falling edge, long after the previous fall moved it.
  task send(input logic kind, slot, input logic [7:0] w);
    backplane_slot_line_n = slot;
    word_kind_qualifier = kind;
    for (int i = 7; i >= 0; i--) begin
      host_serial_in = w[i];
      #100 shift_clock = 1;
      #100 rd = {rd[6:0], module_serial_out};
      shift_clock = 0;
    end
    host_serial_in = !w[0];
  endtask
  task pulse;
    #100 scan_clock = 1;
    #100 scan_clock = 0;
  endtask
endmodule // host_model

/* File: verification/testbench.sv */
// Bench for scan_link with the host model.
// Assumes the checker binds itself to the dut.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0;
  logic rst = 1;
  logic [2:0] c;
  logic [7:0] v;
  wire host_serial_in, shift_clock, word_kind_qualifier, scan_clock;
  wire backplane_slot_line_n, module_serial_out, mux_mode;
  wire [2:0] main_out_select;
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  always #12.5 clk = ~clk;
  scan_link dut (.clk, .rst, .host_serial_in, .shift_clock,
    .word_kind_qualifier, .backplane_slot_line_n, .scan_clock,
    .module_serial_out, .main_out_select, .mux_mode);
  host_model host (.host_serial_in, .shift_clock, .word_kind_qualifier,
    .backplane_slot_line_n, .scan_clock, .module_serial_out);
  task check(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [2:0] exp_sel(input int pulses);
    return 3'(pulses % 8);
  endfunction
  task settle;
    repeat (8) @(posedge clk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    n = $urandom(32'h5a142e9d);
    repeat (3) @(posedge clk);
    #1 rst = 0;
    check(main_out_select, 3'h0);
    settle;
    host.send(1, 1, 8'h00);
    host.send(0, 1, 8'h01);
    host.send(0, 0, 8'h00);
    settle;
    check({2'h0, mux_mode}, 3'h1);
    n = 9 + $urandom_range(6);
    repeat (n) host.pulse;
    settle;
    check(main_out_select, exp_sel(n));
    c = 3'(1 + $urandom_range(6));
    v = {5'($urandom), c};
    host.send(1, 1, 8'h01);
    host.send(0, 1, v);
    host.send(1, 1, 8'h01);
    host.send(0, 1, v);
    check({1'h0, host.rd[6:0]}, {1'h0, v[7:1]});
    settle;
    check({7'h00, module_serial_out}, {7'h00, v[7]});
    host.send(1, 1, 8'h00);
    host.send(0, 1, 8'h00);
    settle;
    check({2'h0, mux_mode}, 3'h0);
    check(main_out_select, c);
    report_and_stop;
  end
  initial begin
    #100us;
    fail_count++;
    report_and_stop;
  end
endmodule // testbench
